/* File: prs_sequencer.sv */
`timescale 1ns/1ps
// How it works
// - power-on pin high: regulators on, reset released
// - power-on pin low or hibernate input low kills all regulators
// - three core regulators start on reset release
// - request is union of three sources
// - clock requests map to resource sets
// - each resource has one of four states
// - timer zero unless resource in transition
// - timer loads delay, counts low-power ticks
// - timer zero clears pending, flips state
// - zero delay means immediate transition
// - required set recomputed every sequencer tick
// - required set compared with status each tick
// - disable only unrequested, enabled, no dependents
// - enable only requested with dependencies enabled
// - doze stops main clocks, sequencer keeps running
// - save core state before deep sleep
// - wake from deep sleep, restore state
// - shutdown tristates outputs, disables inputs
// - power-on after shutdown is fresh power-up
// - hibernate input low disables regulators
// - pin pull-down on after reset, software off
module prs_sequencer import prs_pkg::*; #(
  parameter int N = NUM_RES,
  parameter int NC = NUM_CLK,
  parameter int TW = TIMER_W,
  parameter int TICK_DIV = LPO_DIV
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  input wire logic power_on_in,
  input wire logic hibernate_power_on_in,
  output logic hibernate_power_on_out,
  output logic power_on_pulldown_en,
  input wire logic ext_irq_in,
  input wire logic usb_resume_in,
  input wire logic [NC-1:0] clk_req,
  output logic [N-1:0] resource_en,
  output logic core_reset_n,
  output logic main_clk_en,
  output logic core_power_en,
  output logic retain_save,
  output logic retain_restore,
  output logic io_out_en,
  output logic io_in_en
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic pon_meta;
    logic pon_s;
    logic hib_meta;
    logic hib_s;
    logic irq_meta;
    logic irq_s;
    logic irq_d;
    logic usb_meta;
    logic usb_s;
    logic usb_d;
  } prs_sync_t;
  typedef struct packed {
    prs_sync_t sy;
    logic pulldown_en;
    logic [N-1:0] min_mask;
    logic [NC-1:0][N-1:0] clk_map;
    logic [N-1:0] tmr_mask;
    logic [TW-1:0] tmr_count;
    logic [N-1:0][TW-1:0] time_on;
    logic [N-1:0][TW-1:0] time_off;
    logic [N-1:0][N-1:0] deps;
    prs_mode_t mode;
    logic retain_save;
    logic retain_restore;
    logic [DATA_W-1:0] rd_data;
  } prs_state_t;
  prs_state_t s, next_s;
  function automatic prs_state_t fresh(input prs_sync_t y);
    prs_state_t f;
    f = '0;
    f.sy = y;
    f.pulldown_en = 1'b1;
    f.min_mask = MIN_MASK_RESET;
    f.mode = MODE_ACTIVE;
    return f;
  endfunction
  function automatic logic [N-1:0] close_deps(
    input logic [N-1:0] r,
    input logic [N-1:0][N-1:0] d
  );
    logic [N-1:0] c;
    c = r;
    for (int k = 0; k < N; k++) begin
      for (int j = 0; j < N; j++) begin
        if (c[j]) begin
          c = c | d[j];
        end
      end
    end
    return c;
  endfunction
  // ------------------------------------------------------------
  // sequencer tick and resource slots
  // ------------------------------------------------------------
  logic tick;
  logic [N-1:0] st;
  logic [N-1:0] pend;
  logic [N-1:0] start_on;
  logic [N-1:0] start_off;
  logic [N-1:0][TW-1:0] timer;
  logic [N-1:0] clk_need;
  logic [N-1:0] requested;
  logic [N-1:0] needed;
  logic [N-1:0] dependents_up;
  logic [N-1:0] deps_ready;
  prs_tick #(.DIV(TICK_DIV), .CW(16)) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .tick(tick)
  );
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_res
      prs_slot #(.TW(TW)) u_slot (
        .ref_clk(ref_clk),
        .srst(srst),
        .clear(~s.sy.pon_s),
        .tick(tick),
        .start_on(start_on[g]),
        .start_off(start_off[g]),
        .time_on(s.time_on[g]),
        .time_off(s.time_off[g]),
        .state(st[g]),
        .pending(pend[g]),
        .timer(timer[g])
      );
    end
  endgenerate
  always_comb begin
    clk_need = '0;
    for (int i = 0; i < NC; i++) begin
      if (clk_req[i]) begin
        clk_need = clk_need | s.clk_map[i];
      end
    end
    requested = s.min_mask | clk_need | ((s.tmr_count != '0) ? s.tmr_mask : '0);
    needed = close_deps(requested, s.deps);
    for (int i = 0; i < N; i++) begin
      dependents_up[i] = 1'b0;
      for (int j = 0; j < N; j++) begin
        if ((st[j] | pend[j]) && s.deps[j][i]) begin
          dependents_up[i] = 1'b1;
        end
      end
      deps_ready[i] = ((s.deps[i] & ~(st & ~pend)) == '0);
    end
    start_off = st & ~pend & ~needed & ~dependents_up;
    start_on = ~st & ~pend & needed & deps_ready;
  end
  // ------------------------------------------------------------
  // bus, request timer and power modes
  // ------------------------------------------------------------
  logic tmr_expire;
  logic wake;
  logic [RES_IDX_W-1:0] res_idx;
  logic [CLK_IDX_W-1:0] clk_idx;
  logic [FLD_W-1:0] fld;
  logic res_hit;
  logic clk_hit;
  logic [DATA_W-1:0] rd_word;
  prs_sync_t keep;
  always_comb begin
    next_s = s;
    keep = '0;
    rd_word = '0;
    res_idx = addr[RES_IDX_LSB +: RES_IDX_W];
    clk_idx = addr[FLD_LSB +: CLK_IDX_W];
    fld = addr[FLD_LSB +: FLD_W];
    res_hit = addr[RES_SEL_BIT];
    clk_hit = (addr[ADDR_W-1 -: 4] == CLKMAP_PAGE);
    next_s.sy.pon_meta = power_on_in;
    next_s.sy.pon_s = s.sy.pon_meta;
    next_s.sy.hib_meta = hibernate_power_on_in;
    next_s.sy.hib_s = s.sy.hib_meta;
    next_s.sy.irq_meta = ext_irq_in;
    next_s.sy.irq_s = s.sy.irq_meta;
    next_s.sy.irq_d = s.sy.irq_s;
    next_s.sy.usb_meta = usb_resume_in;
    next_s.sy.usb_s = s.sy.usb_meta;
    next_s.sy.usb_d = s.sy.usb_s;
    next_s.retain_save = 1'b0;
    next_s.retain_restore = 1'b0;
    tmr_expire = tick && (s.tmr_count == TW'(1));
    wake = tmr_expire || (s.sy.irq_s && !s.sy.irq_d) || (s.sy.usb_s && !s.sy.usb_d);
    if (tick && s.tmr_count != '0) begin
      next_s.tmr_count = s.tmr_count - TW'(1);
    end
    if (wr_en) begin
      case (addr)
        ADDR_CTRL: next_s.pulldown_en = wr_data[CTRL_PULLDOWN_BIT];
        ADDR_MIN_MASK: next_s.min_mask = wr_data[N-1:0];
        ADDR_TMR_MASK: next_s.tmr_mask = wr_data[N-1:0];
        ADDR_TMR_COUNT: next_s.tmr_count = wr_data[TW-1:0];
        default: ;
      endcase
      if (clk_hit) begin
        next_s.clk_map[clk_idx] = wr_data[N-1:0];
      end
      if (res_hit) begin
        case (fld)
          FLD_TIME_ON: next_s.time_on[res_idx] = wr_data[TW-1:0];
          FLD_TIME_OFF: next_s.time_off[res_idx] = wr_data[TW-1:0];
          FLD_DEPS: next_s.deps[res_idx] = wr_data[N-1:0];
          default: ;
        endcase
      end
    end
    case (s.mode)
      MODE_ACTIVE: begin
        if (wr_en && addr == ADDR_CTRL && wr_data[CTRL_SLEEP_BIT]) begin
          next_s.mode = MODE_SAVE;
          next_s.retain_save = 1'b1;
        end else if (wr_en && addr == ADDR_CTRL && wr_data[CTRL_DOZE_BIT]) begin
          next_s.mode = MODE_DOZE;
        end
      end
      MODE_DOZE: begin
        if (wake) begin
          next_s.mode = MODE_ACTIVE;
        end
      end
      MODE_SAVE: next_s.mode = MODE_SLEEP;
      MODE_SLEEP: begin
        if (wake) begin
          next_s.mode = MODE_RESTORE;
          next_s.retain_restore = 1'b1;
        end
      end
      MODE_RESTORE: next_s.mode = MODE_ACTIVE;
      default: next_s.mode = MODE_ACTIVE;
    endcase
    if (addr == ADDR_CTRL) begin
      rd_word[CTRL_PULLDOWN_BIT] = s.pulldown_en;
      rd_word[CTRL_MODE_LSB +: 5] = s.mode;
    end else if (addr == ADDR_MIN_MASK) begin
      rd_word[N-1:0] = s.min_mask;
    end else if (addr == ADDR_TMR_MASK) begin
      rd_word[N-1:0] = s.tmr_mask;
    end else if (addr == ADDR_TMR_COUNT) begin
      rd_word[TW-1:0] = s.tmr_count;
    end else if (addr == ADDR_STATE) begin
      rd_word[N-1:0] = st;
    end else if (addr == ADDR_PENDING) begin
      rd_word[N-1:0] = pend;
    end else if (addr == ADDR_NEEDED) begin
      rd_word[N-1:0] = needed;
    end else if (clk_hit) begin
      rd_word[N-1:0] = s.clk_map[clk_idx];
    end else if (res_hit) begin
      case (fld)
        FLD_TIME_ON: rd_word[TW-1:0] = s.time_on[res_idx];
        FLD_TIME_OFF: rd_word[TW-1:0] = s.time_off[res_idx];
        FLD_DEPS: rd_word[N-1:0] = s.deps[res_idx];
        default: rd_word = '0;
      endcase
    end
    next_s.rd_data = rd_en ? rd_word : '0;
    if (!s.sy.pon_s) begin
      keep = next_s.sy;
      next_s = fresh(keep);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= fresh('0);
    end else begin
      s <= next_s;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // regulators follow the power-on pin
  // the pin or the hibernate input gates all regulators off
  assign resource_en = st & {N{s.sy.pon_s & s.sy.hib_s}};
  assign core_reset_n = s.sy.pon_s;
  assign hibernate_power_on_out = s.sy.hib_s;
  assign power_on_pulldown_en = s.pulldown_en;
  assign rd_data = s.rd_data;
  assign retain_save = s.retain_save;
  assign retain_restore = s.retain_restore;
  // main clocks stop in doze and sleep
  assign main_clk_en = s.sy.pon_s && (s.mode != MODE_DOZE) && (s.mode != MODE_SLEEP);
  assign core_power_en = s.sy.pon_s && (s.mode != MODE_SLEEP);
  assign io_out_en = s.sy.pon_s;
  assign io_in_en = s.sy.pon_s;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence save_step_s;
    retain_save && core_power_en ##1 !retain_save && !core_power_en;
  endsequence
  sequence restore_step_s;
    s.mode == MODE_RESTORE && retain_restore ##1 s.mode == MODE_ACTIVE && main_clk_en;
  endsequence
  power_clear_a: assert property (
    !s.sy.pon_s |=> st == '0 && pend == '0 && resource_en == '0)
    else $error("state not cleared while powered off");
  fresh_power_a: assert property (
    $fell(s.sy.pon_s) |=> s.mode == MODE_ACTIVE && s.min_mask == MIN_MASK_RESET)
    else $error("state kept across shutdown");
  save_order_a: assert property (
    s.mode == MODE_ACTIVE && wr_en && addr == ADDR_CTRL && wr_data[CTRL_SLEEP_BIT]
    && s.sy.pon_s && s.sy.pon_meta |=> save_step_s)
    else $error("save did not precede core power off");
  wake_restore_a: assert property (
    s.mode == MODE_SLEEP && wake && s.sy.pon_s && s.sy.pon_meta |=> restore_step_s)
    else $error("wake did not restore core");
  doze_clock_a: assert property (
    s.mode == MODE_ACTIVE && wr_en && addr == ADDR_CTRL && wr_data[CTRL_DOZE_BIT]
    && !wr_data[CTRL_SLEEP_BIT] && s.sy.pon_s && s.sy.pon_meta
    |=> !main_clk_en && core_power_en)
    else $error("main clocks still running in doze");
  keep_needed_a: assert property (
    s.sy.pon_s && s.sy.pon_meta && tick && (st & ~pend & needed) != '0
    |=> ((st & ~pend) & $past(st & ~pend & needed)) == $past(st & ~pend & needed))
    else $error("needed resource started turning off");
  pulldown_rst_a: assert property (
    $past(srst) |-> power_on_pulldown_en)
    else $error("pull-down not enabled after reset");
  hib_off_a: assert property (
    !hibernate_power_on_in ##1 !hibernate_power_on_in |=> resource_en == '0)
    else $error("regulators on with hibernate input low");
endmodule

/* File: prs_pkg.sv */
package prs_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_RES = 8;
  localparam int NUM_CLK = 4;
  localparam int TIMER_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int RES_IDX_W = 3;
  localparam int CLK_IDX_W = 2;
  localparam int FLD_W = 2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int REF_CLK_HZ = 250_000_000;
  localparam int LPO_HZ = 32_768;
  localparam int LPO_DIV = REF_CLK_HZ / LPO_HZ;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_MIN_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TMR_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TMR_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PENDING = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_NEEDED = 8'h18;
  localparam logic [3:0] CLKMAP_PAGE = 4'h4;
  localparam int RES_SEL_BIT = 7;
  localparam int RES_IDX_LSB = 4;
  localparam int FLD_LSB = 2;
  localparam logic [FLD_W-1:0] FLD_TIME_ON = 2'h0;
  localparam logic [FLD_W-1:0] FLD_TIME_OFF = 2'h1;
  localparam logic [FLD_W-1:0] FLD_DEPS = 2'h2;
  localparam int CTRL_PULLDOWN_BIT = 0;
  localparam int CTRL_DOZE_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CTRL_MODE_LSB = 8;
  // ------------------------------------------------------------
  // reset values and resources
  // ------------------------------------------------------------
  localparam logic [NUM_RES-1:0] MIN_MASK_RESET = 8'h07;
  localparam int RES_CORE_BUCK = 0;
  localparam int RES_CORE_LINEAR = 1;
  localparam int RES_LOW_NOISE_LINEAR = 2;
  typedef enum logic [4:0] {
    MODE_ACTIVE = 5'h01,
    MODE_DOZE = 5'h02,
    MODE_SAVE = 5'h04,
    MODE_SLEEP = 5'h08,
    MODE_RESTORE = 5'h10
  } prs_mode_t;
endpackage

/* File: prs_tick.sv */
`timescale 1ns/1ps
module prs_tick import prs_pkg::*; #(
  parameter int DIV = LPO_DIV,
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  output logic tick
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } prs_tick_t;
  prs_tick_t s, next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == CW'(DIV - 1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

/* File: prs_slot.sv */
`timescale 1ns/1ps
module prs_slot import prs_pkg::*; #(
  parameter int TW = TIMER_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic tick,
  input wire logic start_on,
  input wire logic start_off,
  input wire logic [TW-1:0] time_on,
  input wire logic [TW-1:0] time_off,
  output logic state,
  output logic pending,
  output logic [TW-1:0] timer
);
  typedef struct packed {
    logic state;
    logic pending;
    logic [TW-1:0] timer;
  } prs_slot_t;
  prs_slot_t s, next_s;

  always_comb begin
    next_s = s;
    if (tick) begin
      if (s.pending) begin
        if (s.timer == TW'(1)) begin
          next_s.timer = '0;
          next_s.pending = 1'b0;
          next_s.state = ~s.state;
        end else begin
          next_s.timer = s.timer - TW'(1);
        end
      end else if (start_on) begin
        if (time_on == '0) begin
          next_s.state = 1'b1;
        end else begin
          next_s.pending = 1'b1;
          next_s.timer = time_on;
        end
      end else if (start_off) begin
        if (time_off == '0) begin
          next_s.state = 1'b0;
        end else begin
          next_s.pending = 1'b1;
          next_s.timer = time_off;
        end
      end
    end
    if (clear) begin
      next_s = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign state = s.state;
  assign pending = s.pending;
  assign timer = s.timer;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  timer_zero_a: assert property (pending == (timer != '0))
    else $error("timer and pending disagree");
  load_delay_a: assert property (
    tick && !pending && start_on && time_on != '0 && !clear
    |=> pending && state == 1'b0 && timer == $past(time_on))
    else $error("enable delay not loaded");
  flip_done_a: assert property (
    tick && pending && timer == TW'(1) && !clear
    |=> !pending && timer == '0 && state != $past(state))
    else $error("transition did not complete");
  instant_on_a: assert property (
    tick && !pending && start_on && time_on == '0 && !clear
    |=> state && !pending)
    else $error("zero delay enable not immediate");
endmodule

/* File: prs_host.sv */
`timescale 1ns/1ps
module prs_host (
  input wire logic ref_clk,
  input wire logic pulldown_en,
  output logic power_on_in,
  output logic hibernate_power_on_in,
  output logic ext_irq_in,
  output logic usb_resume_in
);
  logic drv_en;
  logic drv_val;
  logic [1:0] wake_q;

  initial begin
    drv_en = 1'b1;
    drv_val = 1'b1;
    hibernate_power_on_in = 1'b1;
    wake_q = 2'h0;
  end

  assign ext_irq_in = wake_q[0];
  assign usb_resume_in = wake_q[1];

  // pull-down level when released
  // without the pull-down a released pin drifts away from its last level
  assign power_on_in = drv_en ? drv_val : (pulldown_en ? 1'b0 : ~drv_val);

  task automatic drive_power(input logic v);
    @(posedge ref_clk);
    drv_en <= 1'b1;
    drv_val <= v;
  endtask

  task automatic release_power();
    @(posedge ref_clk);
    drv_en <= 1'b0;
  endtask

  task automatic set_hib(input logic v);
    @(posedge ref_clk);
    hibernate_power_on_in <= v;
  endtask

  // level held until lowered, so the synchroniser sees it
  task automatic set_wake(input int src, input logic v);
    @(posedge ref_clk);
    wake_q[src] <= v;
  endtask
endmodule

/* File: prs_sequencer_test.sv */
`timescale 1ns/1ps
module prs_sequencer_test import prs_pkg::*;;
  localparam int DIV = 8;
  localparam int LIMIT = 5000;
  logic ref_clk, srst, wr_en, rd_en, power_on_in, hib_in, hib_out, pd_en, irq, usb;
  logic core_reset_n, main_clk_en, core_power_en, retain_save, retain_restore;
  logic io_out_en, io_in_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [NUM_CLK-1:0] clk_req;
  logic [NUM_RES-1:0] resource_en;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int t0;

  prs_sequencer #(.TICK_DIV(DIV)) i_prs_sequencer (.ref_clk(ref_clk), .srst(srst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .power_on_in(power_on_in), .hibernate_power_on_in(hib_in),
    .hibernate_power_on_out(hib_out), .power_on_pulldown_en(pd_en), .ext_irq_in(irq),
    .usb_resume_in(usb), .clk_req(clk_req), .resource_en(resource_en),
    .core_reset_n(core_reset_n), .main_clk_en(main_clk_en), .core_power_en(core_power_en),
    .retain_save(retain_save), .retain_restore(retain_restore), .io_out_en(io_out_en),
    .io_in_en(io_in_en));

  prs_host i_prs_host (.ref_clk(ref_clk), .pulldown_en(pd_en), .power_on_in(power_on_in),
    .hibernate_power_on_in(hib_in), .ext_irq_in(irq), .usb_resume_in(usb));

  // ------------------------------------------------------------
  // clock, watchdog and helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    check(name, rd_data, exp);
  endtask

  function automatic logic [7:0] tbl(input int r, input int f);
    return 8'h80 + 8'(16 * r + 4 * f);
  endfunction

  task automatic wait_en(input int idx, input logic v);
    for (int i = 0; i < 200 && resource_en[idx] !== v; i++) step(1);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    srst = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    clk_req = 4'h0;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    step(4);
    check("pulldown", pd_en, 32'h1);
    check("core_reset_n", core_reset_n, 32'h1);
    check("io_out_en", io_out_en, 32'h1);
    rd_chk("ctrl", ADDR_CTRL, 32'h101);
    rd_chk("min_mask", ADDR_MIN_MASK, 32'h07);
    step(1);
    check("rd_once", rd_data, 32'h0);
    rd_chk("unmapped", 8'h3C, 32'h0);
    step(DIV + 2);
    check("core_regs_on", resource_en, 32'h07);
    wr(ADDR_STATE, 32'hFF);
    rd_chk("state_ro", ADDR_STATE, 32'h07);
    rd_chk("pending_idle", ADDR_PENDING, 32'h0);
    // timed enable of resource 3
    wr(tbl(3, 0), 32'h3);
    wr(tbl(3, 1), 32'h2);
    rd_chk("time_on", tbl(3, 0), 32'h3);
    wr(ADDR_MIN_MASK, 32'h0F);
    t0 = cyc;
    step(DIV + 2);
    rd_chk("pending_on", ADDR_PENDING, 32'h08);
    rd_chk("state_on", ADDR_STATE, 32'h07);
    wait_en(3, 1'b1);
    check("on_delay", (cyc - t0 >= 25) && (cyc - t0 <= 34), 32'h1);
    rd_chk("pending_done", ADDR_PENDING, 32'h0);
    // resource 4 depends on resource 5
    wr(tbl(4, 2), 32'h20);
    wr(tbl(5, 0), 32'h2);
    wr(ADDR_MIN_MASK, 32'h1F);
    step(2);
    rd_chk("needed", ADDR_NEEDED, 32'h3F);
    wait_en(5, 1'b1);
    check("dep_first", resource_en[4], 32'h0);
    step(DIV + 2);
    check("dep_on", resource_en, 32'h3F);
    wr(ADDR_MIN_MASK, 32'h07);
    wait_en(5, 1'b0);
    check("dependent_first", resource_en[4], 32'h0);
    step(3 * DIV);
    check("all_off", resource_en, 32'h07);
    // clock request and request timer
    wr(8'h48, 32'h40);
    clk_req <= 4'h4;
    step(DIV + 3);
    check("clk_map_on", resource_en, 32'h47);
    clk_req <= 4'h0;
    step(DIV + 3);
    check("clk_map_off", resource_en, 32'h07);
    wr(ADDR_TMR_MASK, 32'h80);
    wr(ADDR_TMR_COUNT, 32'h3);
    step(DIV + 3);
    check("tmr_on", resource_en, 32'h87);
    step(3 * DIV);
    check("tmr_off", resource_en, 32'h07);
    wr(ADDR_TMR_MASK, 32'h0);
    // doze, woken by the interrupt pin
    wr(ADDR_CTRL, 32'h3);
    step(1);
    check("doze_clk", main_clk_en, 32'h0);
    check("doze_power", core_power_en, 32'h1);
    rd_chk("doze_mode", ADDR_CTRL, 32'h201);
    i_prs_host.set_wake(0, 1'b1);
    for (int i = 0; i < 20 && main_clk_en !== 1'b1; i++) step(1);
    check("doze_wake", main_clk_en, 32'h1);
    i_prs_host.set_wake(0, 1'b0);
    step(4);
    // deep sleep, woken by interrupt, usb resume and timer
    for (int src = 0; src < 3; src++) begin
      if (src == 2) begin
        wr(ADDR_TMR_COUNT, 32'h2);
      end
      wr(ADDR_CTRL, 32'h5);
      #1;
      check("save", retain_save, 32'h1);
      check("save_power", core_power_en, 32'h1);
      step(1);
      check("save_once", retain_save, 32'h0);
      check("sleep_power", core_power_en, 32'h0);
      check("sleep_regs", resource_en, 32'h07);
      if (src < 2) begin
        i_prs_host.set_wake(src, 1'b1);
      end
      for (int i = 0; i < 2 * DIV + 20 && retain_restore !== 1'b1; i++) step(1);
      check("restore", retain_restore, 32'h1);
      check("restore_power", core_power_en, 32'h1);
      step(1);
      check("active", main_clk_en, 32'h1);
      if (src < 2) begin
        i_prs_host.set_wake(src, 1'b0);
      end
      step(4);
    end
    // hibernate pin
    i_prs_host.set_hib(1'b0);
    step(4);
    check("hib_regs", resource_en, 32'h0);
    check("hib_out", hib_out, 32'h0);
    i_prs_host.set_hib(1'b1);
    step(4);
    check("hib_back", resource_en, 32'h07);
    // pull-down control, then power cycle
    wr(ADDR_CTRL, 32'h0);
    step(1);
    check("pulldown_off", pd_en, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    i_prs_host.release_power();
    step(4);
    check("pin_pulled", power_on_in, 32'h0);
    check("off_regs", resource_en, 32'h0);
    check("off_reset", core_reset_n, 32'h0);
    check("off_clk", main_clk_en, 32'h0);
    check("off_io", {io_out_en, io_in_en}, 32'h0);
    wr(ADDR_MIN_MASK, 32'hFF);
    i_prs_host.drive_power(1'b1);
    step(4);
    rd_chk("min_fresh", ADDR_MIN_MASK, 32'h07);
    rd_chk("table_fresh", tbl(3, 0), 32'h0);
    rd_chk("ctrl_fresh", ADDR_CTRL, 32'h101);
    step(DIV + 2);
    check("fresh_regs", resource_en, 32'h07);
    finish_test();
  end
endmodule
